// ---- bcc_pkg.sv ----
// bcc_pkg: constants, types and register map of the boot configuration capture block
// assumes a single 20 MHz system clock and a classic wishbone register port
//
// Overview of operation
// - strap 0 means 100 MHz, 1 means 125 MHz
// - core runs from port 0 pll clock
// - bypass mode drives core from reference clock
// - all straps sampled together at reset release
// - strap changes ignored outside the sampling point
// - status register shows last captured straps
// - loader may write any writable register bit
// - downstream strap seeds downstream slot clock bits
// - upstream strap seeds upstream slot clock bit
// - slow strap gives 100 kHz, else 400 kHz
// - halt strap keeps device halted after reset
// - halt exits only when agent clears bit
// - mode 0 normal, 1 eeprom, 7 bypass, 2-6 reserved
// - halt bit writable, overriding the strap
// - software reset reuses previously captured straps
package bcc_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] BCC_ADDR_STATUS = 8'h00;
    localparam logic [7:0] BCC_ADDR_CONTROL = 8'h04;
    localparam logic [7:0] BCC_ADDR_LINK0 = 8'h08;
    localparam int BCC_NUM_PORTS = 4;
    // ==========================================================
    // status field positions
    localparam int BCC_ST_HALTED = 8;
    localparam int BCC_ST_RSVD_MODE = 9;
    localparam int BCC_ST_BYPASS = 10;
    // control field positions
    localparam int BCC_CTL_HALT = 0;
    localparam int BCC_CTL_FRST = 1;
    // link status slot clock bit
    localparam int BCC_LNK_SCLK = 0;
    // ==========================================================
    // operating mode codes
    localparam logic [2:0] BCC_MODE_NORMAL = 3'h0;
    localparam logic [2:0] BCC_MODE_EEPROM = 3'h1;
    localparam logic [2:0] BCC_MODE_BYPASS_DEF = 3'h7;
    // ==========================================================
    // timing: master smbus rates
    localparam int BCC_CLK_KHZ = 20000;
    localparam int BCC_SMB_FAST_KHZ = 400;
    localparam int BCC_SMB_SLOW_KHZ = 100;
    localparam int BCC_SMB_FAST_CYC = (BCC_CLK_KHZ + BCC_SMB_FAST_KHZ - 1) / BCC_SMB_FAST_KHZ;
    localparam int BCC_SMB_SLOW_CYC = (BCC_CLK_KHZ + BCC_SMB_SLOW_KHZ - 1) / BCC_SMB_SLOW_KHZ;
    localparam int BCC_DIV_W = 8;
    // ==========================================================
    // captured strap vector, msb first
    typedef struct packed {
        logic [2:0] mode;
        logic halt;
        logic smb_slow;
        logic cclk_us;
        logic cclk_ds;
        logic refclk;
    } bcc_strap_s;
    localparam int BCC_STRAP_W = $bits(bcc_strap_s);
    localparam bcc_strap_s BCC_STRAP_RST = '0;
    // sequencer states
    typedef enum logic [2:0] {ST_RESET, ST_INIT, ST_LOAD, ST_HALT, ST_RUN} bcc_state_e;
endpackage

// ---- bcc_capture.sv ----
// bcc_capture: strap capture, reset halt sequencing, clock selection and smbus rate tick
// assumes strap and reset pins are asynchronous to sys_clk; wishbone master on sys_clk
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
module bcc_capture
    import bcc_pkg::*;
#(
    parameter logic [2:0] BYPASS_CODE = BCC_MODE_BYPASS_DEF
)
(
    // clock and power-on reset
    input wire logic sys_clk,
    input wire logic rstn,
    // board pins
    input wire logic fundamental_reset_n,
    input wire logic refclk_freq_select,
    input wire logic [2:0] switch_op_select,
    input wire logic common_clk_downstream,
    input wire logic common_clk_upstream,
    input wire logic master_smb_slow_select,
    input wire logic halt_after_reset,
    // eeprom loader handshake
    input wire logic eeprom_done,
    input wire logic eeprom_error,
    output logic eeprom_load_req,
    // clocking and core control
    output logic core_clk_bypass,
    output logic refclk_is_125,
    output logic core_reset_n,
    output logic halted,
    output logic smb_tick,
    output logic [BCC_NUM_PORTS-1:0] slot_clk_cfg,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // ==========================================================
    // pin synchronisers
    localparam int PIN_W = BCC_STRAP_W + 1;
    logic [PIN_W-1:0] pin_raw; // reset pin on top, straps below
    logic [PIN_W-1:0] sync1; // metastable stage, feeds sync2 only
    logic [PIN_W-1:0] sync2;
    logic [PIN_W-1:0] sync3;
    logic [PIN_W-1:0] pin_stable; // filtered level per pin
    logic pin_prev; // last stable reset pin level
    wire bcc_strap_s strap_now = pin_stable[BCC_STRAP_W-1:0];
    wire pin_rst_n = pin_stable[PIN_W-1];
    assign pin_raw = {fundamental_reset_n, switch_op_select, halt_after_reset,
                      master_smb_slow_select, common_clk_upstream,
                      common_clk_downstream, refclk_freq_select};

    // three-stage sync chain
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end
        else
        begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // a pin change counts once stage two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++)
        begin : g_filt
            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                    pin_stable[gi] <= 1'b0;
                else if (sync2[gi] == sync3[gi])
                    pin_stable[gi] <= sync3[gi];
            end
        end
    endgenerate

    // release edge of the fundamental reset pin
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            pin_prev <= 1'b0;
        else
            pin_prev <= pin_rst_n;
    end
    wire pin_release = pin_rst_n & ~pin_prev;

    // ==========================================================
    // state and registers
    bcc_state_e state;
    bcc_state_e next_state;
    bcc_strap_s captured; // vector of the last pin reset
    logic ctl_halt; // halt-after-reset control bit
    logic frst_req; // software fundamental reset pulse
    logic [BCC_NUM_PORTS-1:0] sclk; // slot clock bits, port 0 upstream

    // bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire sel_ctl = (wb_adr_i == BCC_ADDR_CONTROL);
    wire [7:0] link_off = wb_adr_i - BCC_ADDR_LINK0;
    wire link_hit = (wb_adr_i >= BCC_ADDR_LINK0) && (link_off[1:0] == 2'b00)
                    && (link_off[7:2] < 6'(BCC_NUM_PORTS));
    wire [1:0] link_idx = link_off[3:2];
    // registers only accept writes once the pin reset is released
    wire wr_ok = bus_wr & (state != ST_RESET);
    wire wr_ctl = wr_ok & sel_ctl;
    wire wr_link = wr_ok & link_hit;
    wire seed = (state == ST_INIT); // reload of registers from vector

    // ==========================================================
    // mode decode
    wire mode_bypass = (captured.mode == BYPASS_CODE);
    wire mode_eeprom = (captured.mode == BCC_MODE_EEPROM);
    wire mode_rsvd = (captured.mode != BCC_MODE_NORMAL) && !mode_eeprom
                     && !mode_bypass;

    // capture: only on the filtered release edge; pins otherwise unseen
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            captured <= BCC_STRAP_RST;
        else if (pin_release)
            captured <= strap_now;
    end

    // sequencer transitions
    always_comb
    begin
        next_state = state;
        case (state)
            ST_RESET:
                if (pin_release)
                    next_state = ST_INIT;
            ST_INIT:
                // eeprom mode loads before halt is judged
                if (mode_eeprom)
                    next_state = ST_LOAD;
                // halt bit is only reseeded at this edge, so judge the vector itself
                else if (captured.halt)
                    next_state = ST_HALT;
                else
                    next_state = ST_RUN;
            ST_LOAD:
                if (eeprom_done || eeprom_error)
                    // a loader error sets the halt bit at this edge, so it halts too
                    next_state = (ctl_halt || eeprom_error) ? ST_HALT : ST_RUN;
            ST_HALT:
                if (!ctl_halt)
                    next_state = ST_RUN;
            ST_RUN:
                if (frst_req)
                    next_state = ST_INIT;
            default:
                next_state = ST_RESET;
        endcase
        // pin reset overrides everything
        if (!pin_rst_n)
            next_state = ST_RESET;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            state <= ST_RESET;
        else
            state <= next_state;
    end

    // halt control bit: seeded from vector, loader error sets, software clears
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            ctl_halt <= 1'b0;
        else if (seed)
            ctl_halt <= captured.halt;
        else if (eeprom_error && state == ST_LOAD)
            ctl_halt <= 1'b1; // set beats a same-cycle clear
        else if (wr_ctl)
            ctl_halt <= wb_dat_i[BCC_CTL_HALT];
    end

    // software fundamental reset, self clearing, only while running
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            frst_req <= 1'b0;
        else
            frst_req <= wr_ctl & wb_dat_i[BCC_CTL_FRST] & (state == ST_RUN);
    end

    // slot clock bits per port
    generate
        for (gi = 0; gi < BCC_NUM_PORTS; gi++)
        begin : g_sclk
            // port 0 seeds from the upstream strap, the rest from downstream
            wire seed_val = (gi == 0) ? captured.cclk_us : captured.cclk_ds;
            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                    sclk[gi] <= 1'b0;
                else if (seed)
                    sclk[gi] <= seed_val;
                else if (wr_link && link_idx == 2'(gi))
                    sclk[gi] <= wb_dat_i[BCC_LNK_SCLK];
            end
        end
    endgenerate

    // ==========================================================
    // master smbus rate divider
    logic [BCC_DIV_W-1:0] div_cnt;
    // rate taken from the captured strap, never from the live pin
    wire [BCC_DIV_W-1:0] div_top = captured.smb_slow ?
        BCC_DIV_W'(BCC_SMB_SLOW_CYC - 1) : BCC_DIV_W'(BCC_SMB_FAST_CYC - 1);
    wire div_run = (state != ST_RESET) && (state != ST_INIT);
    wire div_wrap = (div_cnt >= div_top);

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_cnt <= '0;
            smb_tick <= 1'b0;
        end
        else if (!div_run)
        begin
            div_cnt <= '0;
            smb_tick <= 1'b0;
        end
        else
        begin
            div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
            smb_tick <= div_wrap;
        end
    end

    // ==========================================================
    // registered core-facing outputs
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            core_clk_bypass <= 1'b0;
            refclk_is_125 <= 1'b0;
            core_reset_n <= 1'b0;
            halted <= 1'b0;
            eeprom_load_req <= 1'b0;
            slot_clk_cfg <= '0;
        end
        else
        begin
            // pll clock unless bypass mode is captured
            core_clk_bypass <= mode_bypass;
            refclk_is_125 <= captured.refclk;
            // core held in reset through init, load and halt
            core_reset_n <= (next_state == ST_RUN);
            halted <= (next_state == ST_HALT);
            eeprom_load_req <= (next_state == ST_LOAD);
            slot_clk_cfg <= sclk;
        end
    end

    // ==========================================================
    // wishbone read mux and ack
    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (wb_adr_i == BCC_ADDR_STATUS)
        begin
            rd_val[BCC_STRAP_W-1:0] = captured;
            rd_val[BCC_ST_HALTED] = (state == ST_HALT);
            rd_val[BCC_ST_RSVD_MODE] = mode_rsvd;
            rd_val[BCC_ST_BYPASS] = mode_bypass;
        end
        else if (sel_ctl)
            rd_val[BCC_CTL_HALT] = ctl_halt;
        else if (link_hit)
            rd_val[BCC_LNK_SCLK] = sclk[link_idx];
    end

    // one wait state: ack the cycle after the request is seen
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_val : 32'h0000_0000;
        end
    end
endmodule

// ---- bcc_capture_chk.sv ----
// bcc_capture_chk: port assertions for bcc_capture
// assumes one clock domain; attached by the bind at the foot
`timescale 1ns/10ps
module bcc_capture_chk
    import bcc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // pins and core control
    input wire logic fundamental_reset_n,
    input wire logic eeprom_done,
    input wire logic eeprom_load_req,
    input wire logic core_clk_bypass,
    input wire logic refclk_is_125,
    input wire logic core_reset_n,
    input wire logic halted,
    input wire logic smb_tick,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // ==========
    // helpers
    logic [3:0] hi_cnt; // cycles the pin has been high
    logic [8:0] gap; // cycles since last tick
    logic gap_ok; // a tick seen since the sequencer left reset or init
    wire ctl_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
        && wb_adr_i == BCC_ADDR_CONTROL;
    wire clr_wr = ctl_wr && !wb_dat_i[BCC_CTL_HALT];
    wire core_idle = !core_reset_n && !halted && !eeprom_load_req;
    // gap_ok drops in reset or init, the divider may restart there
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hi_cnt <= 4'h0;
            gap <= 9'h000;
            gap_ok <= 1'b0;
        end
        else
        begin
            hi_cnt <= !fundamental_reset_n ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hF};
            gap <= smb_tick ? 9'h001 : gap + {8'h00, gap != 9'h1FF};
            gap_ok <= core_idle ? 1'b0 : (gap_ok || smb_tick);
        end
    end
    // software reset request taken in run
    sequence s_frst_wr;
        ctl_wr && wb_dat_i[BCC_CTL_FRST] && core_reset_n;
    endsequence
    // ==========
    // assertions
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data without ack");
    chk_capture_hold: assert property (hi_cnt == 4'hF |-> $stable(refclk_is_125)
        && $stable(core_clk_bypass))
        else $error("captured value moved");
    chk_run_exclusive: assert property (core_reset_n |-> !halted && !eeprom_load_req)
        else $error("run while halted or loading");
    chk_halt_exit: assert property ($fell(halted) && core_reset_n |->
        $past(clr_wr, 1) || $past(clr_wr, 2) || $past(clr_wr, 3))
        else $error("halt left without clear");
    chk_load_done: assert property (eeprom_load_req && eeprom_done |=> !eeprom_load_req)
        else $error("load not ended");
    chk_sw_reset: assert property (s_frst_wr |-> ##[1:4] !core_reset_n)
        else $error("software reset missing");
    chk_tick_period: assert property (smb_tick && gap_ok |->
        gap == BCC_SMB_FAST_CYC || gap == BCC_SMB_SLOW_CYC)
        else $error("tick period wrong");
endmodule
bind bcc_capture bcc_capture_chk bcc_capture_chk_inst (
    .sys_clk(sys_clk), .rstn(rstn), .fundamental_reset_n(fundamental_reset_n),
    .eeprom_done(eeprom_done), .eeprom_load_req(eeprom_load_req),
    .core_clk_bypass(core_clk_bypass), .refclk_is_125(refclk_is_125),
    .core_reset_n(core_reset_n), .halted(halted), .smb_tick(smb_tick),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);

// ---- bcc_board.sv ----
// bcc_board: strap pins and fundamental reset source of the board
// assumes sys_clk from the bench; pins change just after its edge
`timescale 1ns/10ps
module bcc_board
    import bcc_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // pins
    output logic fundamental_reset_n,
    output bcc_strap_s strap
);
    // pin held low from power up
    initial
    begin
        fundamental_reset_n = 1'b0;
        strap = BCC_STRAP_RST;
    end
    // ==========
    // pin reset; straps scrambled after the hold so a late sample shows
    task automatic pin_reset(input bcc_strap_s v);
        @(posedge sys_clk);
        fundamental_reset_n <= 1'b0;
        strap <= v;
        repeat (4) @(posedge sys_clk);
        fundamental_reset_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        strap <= ~v;
        @(posedge sys_clk);
    endtask
endmodule

// ---- testbench.sv ----
// testbench: scenarios for bcc_capture with a board model
// assumes bcc_board drives the pins and wishbone acts as agent
`timescale 1ns/10ps
`define CHECK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("MISMATCH %0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
module testbench
    import bcc_pkg::*;
;
    logic sys_clk;
    logic rstn;
    logic eeprom_done;
    logic eeprom_error; // loader error pulse
    logic fundamental_reset_n;
    bcc_strap_s strap;
    logic eeprom_load_req, core_clk_bypass, refclk_is_125, core_reset_n, halted, smb_tick;
    logic [3:0] slot_clk_cfg;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    int n_mismatch;
    int samples_checked;
    bcc_board bcc_board_inst (.sys_clk(sys_clk), .fundamental_reset_n(fundamental_reset_n),
        .strap(strap));
    bcc_capture bcc_capture_inst (.sys_clk(sys_clk), .rstn(rstn),
        .fundamental_reset_n(fundamental_reset_n), .refclk_freq_select(strap.refclk),
        .switch_op_select(strap.mode), .common_clk_downstream(strap.cclk_ds),
        .common_clk_upstream(strap.cclk_us), .master_smb_slow_select(strap.smb_slow),
        .halt_after_reset(strap.halt), .eeprom_done(eeprom_done), .eeprom_error(eeprom_error),
        .eeprom_load_req(eeprom_load_req), .core_clk_bypass(core_clk_bypass),
        .refclk_is_125(refclk_is_125), .core_reset_n(core_reset_n), .halted(halted),
        .smb_tick(smb_tick), .slot_clk_cfg(slot_clk_cfg), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    // 20 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ==========
    // one classic cycle; read data lands in rd at the ack edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        // no cycle count assumed; only the watchdog ends a hung wait
        do
            @(posedge sys_clk);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // cycles between two ticks, bounded
    task automatic tick_gap(output int g);
        int n;
        n = 0;
        while (smb_tick !== 1'b1 && n < 500)
        begin
            @(posedge sys_clk);
            n++;
        end
        g = 0;
        do
        begin
            @(posedge sys_clk);
            g++;
        end
        while (smb_tick !== 1'b1 && g < 500);
    endtask
    // ==========
    // mode codes 0 to 6; mode 1 loads, agent sets halt during the load, then clears it
    task automatic t_modes();
        bcc_strap_s v;
        for (int m = 0; m < 7; m++)
        begin
            v = '0;
            v.mode = m[2:0];
            bcc_board_inst.pin_reset(v);
            `CHECK(eeprom_load_req, logic'(m == 1))
            if (m == 1)
            begin
                wb(1'b1, BCC_ADDR_CONTROL, 32'h1);
                eeprom_done <= 1'b1;
                @(posedge sys_clk);
                eeprom_done <= 1'b0;
                repeat (2) @(posedge sys_clk);
                `CHECK(halted, 1'b1)
                wb(1'b1, BCC_ADDR_CONTROL, 32'h0);
                repeat (2) @(posedge sys_clk);
            end
            wb(1'b0, BCC_ADDR_STATUS, 32'h0);
            `CHECK(rd[10:9], {1'b0, logic'(m > 1)})
            `CHECK(core_reset_n, 1'b1)
        end
        // loader error ends the load and sets the halt bit
        bcc_board_inst.pin_reset({BCC_MODE_EEPROM, 5'b00000});
        eeprom_error <= 1'b1;
        @(posedge sys_clk);
        eeprom_error <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHECK({halted, eeprom_load_req}, 2'b10)
        wb(1'b1, BCC_ADDR_CONTROL, 32'h0);
        repeat (2) @(posedge sys_clk);
        `CHECK(core_reset_n, 1'b1)
        $display("modes test done");
    endtask
    // capture with ignored late strap changes, slow smbus rate
    task automatic t_capture();
        int g;
        bcc_board_inst.pin_reset({BCC_MODE_NORMAL, 5'b01101});
        wb(1'b0, BCC_ADDR_STATUS, 32'h0);
        `CHECK(rd[7:0], {BCC_MODE_NORMAL, 5'b01101})
        `CHECK(refclk_is_125, 1'b1)
        `CHECK(slot_clk_cfg, 4'b0001)
        tick_gap(g);
        `CHECK(g, BCC_SMB_SLOW_CYC)
        $display("capture test done");
    endtask
    // software reset reuses old vector; status is read only
    task automatic t_swreset();
        wb(1'b1, BCC_ADDR_LINK0, 32'h0);
        // output register lags the bit by one cycle
        @(posedge sys_clk);
        `CHECK(slot_clk_cfg, 4'b0000)
        wb(1'b1, BCC_ADDR_STATUS, 32'hFF);
        wb(1'b1, BCC_ADDR_CONTROL, 32'h2);
        repeat (6) @(posedge sys_clk);
        `CHECK(slot_clk_cfg, 4'b0001)
        wb(1'b0, BCC_ADDR_STATUS, 32'h0);
        `CHECK(rd[7:0], {BCC_MODE_NORMAL, 5'b01101})
        wb(1'b0, 8'h40, 32'h0);
        `CHECK(rd, 32'h0)
        $display("software reset test done");
    endtask
    // bypass with halt strap, fast rate, slot override, then release
    task automatic t_bypass();
        int g;
        bcc_board_inst.pin_reset({BCC_MODE_BYPASS_DEF, 5'b10010});
        `CHECK({halted, core_reset_n, core_clk_bypass}, 3'b101)
        `CHECK(slot_clk_cfg, 4'b1110)
        wb(1'b0, BCC_ADDR_STATUS, 32'h0);
        `CHECK(rd[10:0], {3'b101, BCC_MODE_BYPASS_DEF, 5'b10010})
        tick_gap(g);
        `CHECK(g, BCC_SMB_FAST_CYC)
        wb(1'b1, BCC_ADDR_LINK0 + 8'h04, 32'h0);
        @(posedge sys_clk);
        `CHECK(slot_clk_cfg, 4'b1100)
        wb(1'b1, BCC_ADDR_CONTROL, 32'h0);
        repeat (2) @(posedge sys_clk);
        `CHECK({halted, core_reset_n}, 2'b01)
        $display("bypass halt test done");
    endtask
    // ==========
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog, several times the expected run
    initial
    begin
        #(8000 * 50);
        n_mismatch++;
        give_verdict();
    end
    // main sequence
    initial
    begin
        n_mismatch = 0;
        samples_checked = 0;
        rstn = 1'b0;
        eeprom_done = 1'b0;
        eeprom_error = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hF;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        t_modes();
        t_capture();
        t_swreset();
        t_bypass();
        give_verdict();
    end
endmodule
